/* bench/serial_ctrl_sva.sv */
// Port-level checks for the async serial controller.
// Assumes one clock and synchronous reset.
`timescale 1ns/1ns
module serial_ctrl_sva
  import serial_ctrl_pkg::*;
(
  input wire logic                                clk_in,
  input wire logic                                srst_in,
  input wire logic                                cfg_write_in,
  input wire logic                                rate_count_reload_in,
  input wire logic [serial_ctrl_pkg::DIV_W-1:0]  rate_count_out,
  input wire logic                                tx_valid_in,
  input wire logic                                tx_ready_out,
  input wire logic                                tx_full_out,
  input wire logic                                tx_empty_out,
  input wire logic                                txd_out,
  input wire logic                                rx_valid_out,
  input wire logic                                rx_ready_in,
  input wire logic [serial_ctrl_pkg::CHAR_W-1:0] rx_data_out,
  input wire logic                                rx_half_out,
  input wire logic                                rx_empty_out,
  input wire logic [serial_ctrl_pkg::INT_W-1:0]  int_enable_in,
  input wire logic [serial_ctrl_pkg::INT_W-1:0]  int_clear_in,
  input wire logic [serial_ctrl_pkg::INT_W-1:0]  int_status_out,
  input wire logic                                irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Push and frame start steps
  sequence push_s; tx_valid_in && tx_ready_out; endsequence
  sequence start_s; $fell(txd_out); endsequence
  ready_full_a: assert property (tx_ready_out == !tx_full_out)
    else $error("ready vs full");
  push_fill_a: assert property (push_s |=> !tx_empty_out)
    else $error("empty after push");
  start_width_a: assert property (start_s |-> !txd_out [*8])
    else $error("start bit cut short");
  rx_hold_a: assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out))
    else $error("rx word dropped");
  rx_upper_a: assert property (rx_valid_out |-> rx_data_out[9] == 1'b0)
    else $error("rx bit 9 not zero");
  irq_level_a: assert property ($stable(int_enable_in) |-> irq_out == |(int_status_out & int_enable_in))
    else $error("irq mismatch");
  sticky_err_a: assert property (int_status_out[INT_PARITY] && !int_clear_in[INT_PARITY] |=> int_status_out[INT_PARITY])
    else $error("parity flag lost");
  rate_down_a: assert property (rate_count_out != 16'h0000 && !rate_count_reload_in && !cfg_write_in
    |=> rate_count_out == $past(rate_count_out) - 16'h0001)
    else $error("rate not counting");
  rx_levels_a: assert property (!(rx_half_out && rx_empty_out))
    else $error("half and empty");
endmodule : serial_ctrl_sva

bind async_serial_controller serial_ctrl_sva i_sva (.*);

/* bench/serial_far_end.sv */
// Far-end transceiver model for both serial lines.
// Assumes the bench sets bit_clks per bit.
`timescale 1ns/1ns
module serial_far_end (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  int bit_clks = 16;
  initial line_out = 1'b1;
  // LSB first from the start bit
  task automatic send_frame(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      line_out = bits[i];
      repeat (bit_clks) @(negedge clk_in);
    end
    line_out = 1'b1;
  endtask : send_frame
  // Samples mid-bit on falling edges
  task automatic catch_frame(input int n, output logic [11:0] bits);
    bits = 12'hfff;
    @(negedge line_in);
    repeat (bit_clks / 2) @(negedge clk_in);
    for (int i = 0; i < n; i++)
    begin
      bits[i] = line_in;
      repeat (bit_clks) @(negedge clk_in);
    end
  endtask : catch_frame
endmodule : serial_far_end

/* bench/tb_async_serial_controller.sv */
// Self-checking bench for the async serial controller.
// Assumes package, design, checker and model compile first.
`timescale 1ns/1ns
module tb_async_serial_controller;
  import serial_ctrl_pkg::*;
  logic        clk_in, srst_in, cfg_write_in, alt, nine, ext, reload, tx_valid, rx_ready;
  logic        rxd, txd, irq, tx_ready, rx_valid, tx_full, tx_empty, tx_idle, rx_empty;
  logic [15:0] div, rate;
  logic [7:0]  mode;
  logic [1:0]  tpc, rpc;
  logic [9:0]  tx_data, rx_data;
  logic [4:0]  int_en, int_clr, int_st;
  int          n_fail = 0;
  int          checks_done = 0;
  async_serial_controller i_dut (.clk_in(clk_in), .srst_in(srst_in), .cfg_write_in(cfg_write_in),
    .bit_rate_divisor_in(div), .mode_control_in(mode), .alternate_sample_toggle_in(alt), .nine_bit_mode_in(nine),
    .extended_char_enable_in(ext), .tx_parity_ctrl_in(tpc), .rx_parity_ctrl_in(rpc), .rate_count_reload_in(reload),
    .rate_count_out(rate), .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .rxd_in(rxd), .txd_out(txd),
    .tx_full_out(tx_full), .tx_half_out(), .tx_empty_out(tx_empty), .tx_idle_out(tx_idle), .rx_full_out(),
    .rx_half_out(), .rx_empty_out(rx_empty), .rx_idle_out(), .int_enable_in(int_en), .int_clear_in(int_clr),
    .int_status_out(int_st), .irq_out(irq));
  serial_far_end i_far (.clk_in(clk_in), .line_in(txd), .line_out(rxd));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // Drive on falling edges to avoid races
  task automatic cfg(input logic [15:0] d, input logic [3:0] f, input logic a, n9, e, input logic [1:0] p);
    @(negedge clk_in);
    {div, mode, alt, nine, ext, tpc, rpc, cfg_write_in} = {d, f, 4'h0, a, n9, e, p, p, 1'b1};
    @(negedge clk_in);
    cfg_write_in = 1'b0;
    i_far.bit_clks = (16 + f) * (d + 1);
  endtask : cfg
  task automatic push(input logic [9:0] d);
    @(negedge clk_in);
    while (tx_ready !== 1'b1) @(negedge clk_in);
    tx_data = d;
    tx_valid = 1'b1;
    @(negedge clk_in);
    tx_valid = 1'b0;
  endtask : push
  task automatic pull(input logic [9:0] exp);
    int k = 0;
    while (rx_valid !== 1'b1 && k < 400)
    begin
      @(negedge clk_in);
      k++;
    end
    chk("rx word", {6'h00, exp}, {6'h00, rx_data});
    rx_ready = 1'b1;
    @(negedge clk_in);
    rx_ready = 1'b0;
  endtask : pull
  task automatic wait_idle;
    while (tx_idle !== 1'b1) @(negedge clk_in);
  endtask : wait_idle
  // Start and bit 0 widths of character 0x001
  task automatic measure(input int d, input logic [3:0] f, input logic a);
    int lo = 0;
    int hi = 0;
    push(10'h001);
    while (txd !== 1'b0) @(negedge clk_in);
    while (txd === 1'b0)
    begin
      lo++;
      @(negedge clk_in);
    end
    while (txd === 1'b1)
    begin
      hi++;
      @(negedge clk_in);
    end
    chk("start clocks", 16'((16 + f) * (d + 1)), 16'(lo));
    chk("bit0 clocks", 16'((16 + (f ^ {3'h0, a})) * (d + 1)), 16'(hi));
    wait_idle();
  endtask : measure
  // Wire bits from the start bit, unused high
  function automatic logic [11:0] frame(input logic [9:0] d, input logic n9, input logic [1:0] p, output int n);
    logic [8:0] dd;
    frame = 12'hfff;
    frame[0] = 1'b0;
    dd = n9 ? d[8:0] : {1'b0, d[7:0]};
    n = 9 + n9;
    for (int i = 1; i < n; i++) frame[i] = dd[i-1];
    if (p[1]) frame[n] = (^dd) ^ p[0];
    n += p[1] + ((p == PC_TWO_STOP) ? 2 : 1);
  endfunction : frame
  initial
  begin
    logic [11:0] eb, got;
    logic [9:0]  d;
    int          n;
    {cfg_write_in, alt, nine, ext, reload, tx_valid, rx_ready, div, mode, tpc, rpc} = '0;
    {tx_data, int_en, int_clr} = '0;
    srst_in = 1'b1;
    repeat (12) @(negedge clk_in);
    srst_in = 1'b0;
    chk("reset flags", 16'h001d, {11'h0, tx_ready, tx_empty, rx_empty, irq, txd});
    measure(27, 4'hf, 1'b0);
    cfg(16'h0001, 4'h0, 1'b0, 1'b0, 1'b0, PC_ONE_STOP);
    measure(1, 4'h0, 1'b0);
    cfg(16'h0002, 4'h5, 1'b1, 1'b0, 1'b0, PC_ONE_STOP);
    measure(2, 4'h5, 1'b1);
    // Every width and frame-ending code, out and back
    for (int k = 0; k < 8; k++)
    begin
      cfg(16'h0000, 4'h0, 1'b0, k[2], 1'b0, k[1:0]);
      d = k[2] ? 10'h1a5 : 10'h3a7;
      eb = frame(d, k[2], k[1:0], n);
      fork
        push(d);
        i_far.catch_frame(n, got);
      join
      chk("tx frame", {4'h0, eb}, {4'h0, got});
      i_far.send_frame(eb, n);
      pull(k[2] ? {1'b0, d[8:0]} : {2'b00, d[7:0]});
    end
    cfg(16'h0000, 4'h0, 1'b0, 1'b0, 1'b0, PC_EVEN);
    int_en = 5'h03;
    eb = frame(10'h0a5, 1'b0, PC_EVEN, n);
    i_far.send_frame(eb ^ 12'h200, n);
    pull(10'h0a5);
    chk("parity flag irq", 16'h0003, {14'h0, int_st[INT_PARITY], irq});
    int_en = 5'h00;
    @(negedge clk_in);
    chk("masked irq", 16'h0000, {15'h0, irq});
    int_clr = 5'h01;
    @(negedge clk_in);
    int_clr = 5'h00;
    @(negedge clk_in);
    chk("parity cleared", 16'h0000, {15'h0, int_st[INT_PARITY]});
    cfg(16'h0000, 4'h0, 1'b0, 1'b0, 1'b0, PC_ONE_STOP);
    eb = frame(10'h05a, 1'b0, PC_ONE_STOP, n);
    i_far.send_frame(eb & ~12'h200, n);
    pull(10'h05a);
    chk("framing flag", 16'h0001, {15'h0, int_st[INT_FRAMING]});
    // Break, then idle characters
    cfg(16'h0000, 4'h0, 1'b0, 1'b1, 1'b1, PC_ONE_STOP);
    fork
      push(BREAK_CHAR);
      i_far.catch_frame(11, got);
    join
    chk("break bits", 16'h0000, {5'h0, got[10:0]});
    wait_idle();
    push(IDLE_CHAR);
    push(10'h055);
    n = 0;
    while (txd === 1'b1 && n < 1000)
    begin
      n++;
      @(negedge clk_in);
    end
    chk("idle length", 16'h0001, {15'h0, n >= 172});
    wait_idle();
    cfg(16'h0003, 4'h0, 1'b0, 1'b0, 1'b0, PC_ONE_STOP);
    reload = 1'b1;
    @(negedge clk_in);
    reload = 1'b0;
    chk("rate reload", 16'h0003, rate);
    @(negedge clk_in);
    chk("rate count", 16'h0002, rate);
    repeat (3) @(negedge clk_in);
    chk("rate wrap", 16'h0003, rate);
    // Slow line so the FIFO fills
    cfg(16'h00ff, 4'h0, 1'b0, 1'b0, 1'b0, PC_ONE_STOP);
    n = 0;
    while (tx_ready === 1'b1 && n < 40)
    begin
      push({2'b00, 8'(n)});
      n++;
    end
    chk("fill depth", 16'h0003, {14'h0, n == 32 || n == 33, tx_full});
    conclude();
  end
  initial
  begin
    #900000;
    n_fail++;
    $display("ERROR watchdog expected finish seen timeout");
    conclude();
  end
endmodule : tb_async_serial_controller

/* rtl/async_serial_controller.sv */
// Full-duplex async serial controller: TX/RX FIFOs, framer, deframer, status.
// Assumes rxd_in is synchronous to clk_in.
//
// Contract
// - Separate TX and RX FIFOs, 32 entries of 10 bits.
// - 8-bit characters in bits 7:0; bits 9:8 stored zero.
// - 9-bit mode: TX bit 9 selects extended characters.
// - TX sends start, data LSB first, parity, stop bits.
// - TX bits start on a rate tick; full start bit.
// - RX waits half a bit, then samples bit centres.
// - RX checks parity, then pushes to RX FIFO.
// - RX errors set flags; interrupt only when enabled.
// - One interrupt output; cause in interrupt status.
// - TX and RX parity may differ; width shared.
// - Mode 0 gives 8 data bits, 1 gives 9.
// - Parity 00 one stop, 01 two stop, 10 even, 11 odd.
// - A bit lasts 16 plus field samples.
// - Sample field is mode control bits 7:4.
// - A sample lasts divisor plus one clocks.
// - System clock; reset rate 115.2 kHz.
// - Alternate mode flips count LSB every other bit.
// - 16-bit divisor; factor is value plus one.
// - Rate counter reloads at zero or on write; readable.
// - Extended 0x200 sends 11 zeros, 0x3ff 11 ones.
`timescale 1ns/1ns
module async_serial_controller
  import serial_ctrl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                         clk_in,
  input  wire logic                         srst_in,
  input  wire logic                         cfg_write_in,
  input  wire logic [serial_ctrl_pkg::DIV_W-1:0] bit_rate_divisor_in,
  input  wire logic [7:0]                   mode_control_in,
  input  wire logic                         alternate_sample_toggle_in,
  input  wire logic                         nine_bit_mode_in,
  input  wire logic                         extended_char_enable_in,
  input  wire logic [1:0]                   tx_parity_ctrl_in,
  input  wire logic [1:0]                   rx_parity_ctrl_in,
  input  wire logic                         rate_count_reload_in,
  output logic      [serial_ctrl_pkg::DIV_W-1:0] rate_count_out,
  input  wire logic [serial_ctrl_pkg::CHAR_W-1:0] tx_data_in,
  input  wire logic                         tx_valid_in,
  output logic                              tx_ready_out,
  output logic      [serial_ctrl_pkg::CHAR_W-1:0] rx_data_out,
  output logic                              rx_valid_out,
  input  wire logic                         rx_ready_in,
  input  wire logic                         rxd_in,
  output logic                              txd_out,
  output logic                              tx_full_out,
  output logic                              tx_half_out,
  output logic                              tx_empty_out,
  output logic                              tx_idle_out,
  output logic                              rx_full_out,
  output logic                              rx_half_out,
  output logic                              rx_empty_out,
  output logic                              rx_idle_out,
  input  wire logic [serial_ctrl_pkg::INT_W-1:0] int_enable_in,
  input  wire logic [serial_ctrl_pkg::INT_W-1:0] int_clear_in,
  output logic      [serial_ctrl_pkg::INT_W-1:0] int_status_out,
  output logic                              irq_out
);
  import serial_ctrl_pkg::*;

  // Latched configuration
  logic [DIV_W-1:0]  divisor;
  logic [SF_W-1:0]   sample_count_field;
  logic              alt_mode;
  logic              nine_bit;
  logic              ext_enable;
  logic [1:0]        tx_pc;
  logic [1:0]        rx_pc;

  // Settings change only on an explicit write
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      divisor            <= RESET_DIVISOR;
      sample_count_field <= RESET_SAMPLE_FIELD;
      alt_mode           <= 1'b0;
      nine_bit           <= 1'b0;
      ext_enable         <= 1'b0;
      tx_pc              <= PC_ONE_STOP;
      rx_pc              <= PC_ONE_STOP;
    end
    else if (cfg_write_in)
    begin
      divisor            <= bit_rate_divisor_in;
      sample_count_field <= mode_control_in[7:4];
      alt_mode           <= alternate_sample_toggle_in;
      nine_bit           <= nine_bit_mode_in;
      ext_enable         <= extended_char_enable_in;
      tx_pc              <= tx_parity_ctrl_in;
      rx_pc              <= rx_parity_ctrl_in;
    end
  end

  // Rate generator and FIFOs
  wire tick;
  stream_if #(.W(CHAR_W)) tx_wr_if ();
  stream_if #(.W(CHAR_W)) tx_rd_if ();
  stream_if #(.W(CHAR_W)) rx_wr_if ();
  stream_if #(.W(CHAR_W)) rx_rd_if ();

  bit_rate_gen #(.W(DIV_W)) u_rate (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .divisor_in (divisor),
    .reload_in  (rate_count_reload_in),
    .count_out  (rate_count_out),
    .tick_out   (tick)
  );

  serial_fifo #(.W(CHAR_W), .DEPTH(DEPTH)) u_tx_fifo (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .wr        (tx_wr_if),
    .rd        (tx_rd_if),
    .full_out  (tx_full_out),
    .half_out  (tx_half_out),
    .empty_out (tx_empty_out)
  );

  serial_fifo #(.W(CHAR_W), .DEPTH(DEPTH)) u_rx_fifo (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .wr        (rx_wr_if),
    .rd        (rx_rd_if),
    .full_out  (rx_full_out),
    .half_out  (rx_half_out),
    .empty_out (rx_empty_out)
  );

  // TX write side: upper bits forced to zero in 8-bit mode
  assign tx_wr_if.valid = tx_valid_in;
  assign tx_wr_if.data  = nine_bit ? tx_data_in : {2'b00, tx_data_in[7:0]};
  assign tx_ready_out   = tx_wr_if.ready;

  // Transmitter decode
  tx_state_t         tx_state;
  logic [SAMP_W-1:0] tx_samp;
  logic [BITN_W-1:0] tx_bitn;
  logic [NINTH_BIT:0] tx_shift;
  logic              tx_par;
  logic              tx_phase;
  wire [BITN_W-1:0]  data_bits = nine_bit ? BITS_9 : BITS_8;
  wire               tx_bit_end = tick &&
                       (tx_samp == bit_samples(sample_count_field, alt_mode, tx_phase) - SAMP_W'(1));
  wire               tx_is_ext  = nine_bit && ext_enable && tx_rd_if.data[EXT_FLAG_BIT];
  wire               tx_ext_lvl = (tx_rd_if.data == IDLE_CHAR);
  assign tx_rd_if.ready = (tx_state == TX_IDLE) && tick;

  // Transmit framer; a new frame only starts on a tick
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      tx_state <= TX_IDLE;
      txd_out  <= 1'b1;
      tx_samp  <= '0;
      tx_bitn  <= '0;
      tx_shift <= '0;
      tx_par   <= 1'b0;
      tx_phase <= 1'b0;
    end
    else if (tx_state == TX_IDLE)
    begin
      if (tick && tx_rd_if.valid)
      begin
        tx_samp  <= '0;
        tx_phase <= 1'b0;
        tx_bitn  <= '0;
        tx_shift <= tx_rd_if.data[NINTH_BIT:0];
        tx_par   <= parity_of(tx_rd_if.data[NINTH_BIT:0], tx_pc[PC_ODD_BIT]);
        tx_state <= tx_is_ext ? TX_EXT : TX_START;
        txd_out  <= tx_is_ext ? tx_ext_lvl : 1'b0;
      end
    end
    else if (tick)
    begin
      tx_samp <= tx_bit_end ? '0 : tx_samp + SAMP_W'(1);
      if (tx_bit_end)
      begin
        tx_phase <= ~tx_phase;
        unique case (tx_state)
          TX_START:
          begin
            txd_out  <= tx_shift[0];
            tx_shift <= tx_shift >> 1;
            tx_state <= TX_DATA;
          end
          TX_DATA:
          begin
            if (tx_bitn == data_bits - BITN_W'(1))
            begin
              tx_bitn  <= '0;
              txd_out  <= tx_pc[PC_PARITY_BIT] ? tx_par : 1'b1;
              tx_state <= tx_pc[PC_PARITY_BIT] ? TX_PAR : TX_STOP;
            end
            else
            begin
              tx_bitn  <= tx_bitn + BITN_W'(1);
              txd_out  <= tx_shift[0];
              tx_shift <= tx_shift >> 1;
            end
          end
          TX_PAR:
          begin
            txd_out  <= 1'b1;
            tx_state <= TX_STOP;
          end
          TX_STOP:
          begin
            if (tx_pc == PC_TWO_STOP && tx_bitn == '0)
              tx_bitn <= BITN_W'(1);
            else
              tx_state <= TX_IDLE;
          end
          TX_EXT:
          begin
            if (tx_bitn == EXT_BITS - BITN_W'(1))
            begin
              txd_out  <= 1'b1;
              tx_state <= TX_IDLE;
            end
            else
              tx_bitn <= tx_bitn + BITN_W'(1);
          end
          TX_IDLE:
            tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  // Receiver decode
  rx_state_t          rx_state;
  logic [SAMP_W-1:0]  rx_samp;
  logic [BITN_W-1:0]  rx_bitn;
  logic [NINTH_BIT:0] rx_shift;
  logic               rx_phase;
  logic               rx_par_err;
  logic               push_valid;
  logic [CHAR_W-1:0]  push_data;
  logic               ev_parity;
  logic               ev_framing;
  logic               ev_overrun;
  wire [SAMP_W-1:0]   rx_len  = bit_samples(sample_count_field, alt_mode, rx_phase);
  wire                rx_mid  = tick && (rx_samp == (rx_len >> 1) - SAMP_W'(1));
  wire                rx_end  = tick && (rx_samp == rx_len - SAMP_W'(1));
  wire                rx_calc = parity_of(rx_shift, rx_pc[PC_ODD_BIT]);
  assign rx_wr_if.valid = push_valid;
  assign rx_wr_if.data  = push_data;

  // Receive deframer; the half-bit wait aligns sampling to bit centres
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rx_state   <= RX_IDLE;
      rx_samp    <= '0;
      rx_bitn    <= '0;
      rx_shift   <= '0;
      rx_phase   <= 1'b0;
      rx_par_err <= 1'b0;
      push_valid <= 1'b0;
      push_data  <= '0;
      ev_parity  <= 1'b0;
      ev_framing <= 1'b0;
      ev_overrun <= 1'b0;
    end
    else
    begin
      push_valid <= 1'b0;
      ev_parity  <= 1'b0;
      ev_framing <= 1'b0;
      ev_overrun <= 1'b0;
      if (tick)
        rx_samp <= (rx_end || (rx_state == RX_HALF && rx_mid)) ? '0 : rx_samp + SAMP_W'(1);
      unique case (rx_state)
        RX_IDLE:
        begin
          rx_samp  <= '0;
          rx_phase <= 1'b0;
          rx_bitn  <= '0;
          rx_shift <= '0;
          if (tick && !rxd_in)
            rx_state <= RX_HALF;
        end
        RX_HALF:
          if (rx_mid)
            rx_state <= rxd_in ? RX_IDLE : RX_DATA;
        RX_DATA:
          if (rx_end)
          begin
            rx_phase          <= ~rx_phase;
            rx_shift[rx_bitn] <= rxd_in;
            rx_bitn           <= rx_bitn + BITN_W'(1);
            if (rx_bitn == data_bits - BITN_W'(1))
              rx_state <= rx_pc[PC_PARITY_BIT] ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (rx_end)
          begin
            rx_phase   <= ~rx_phase;
            rx_par_err <= (rxd_in != rx_calc);
            rx_state   <= RX_STOP;
          end
        RX_STOP:
          if (rx_end)
          begin
            push_valid <= 1'b1;
            push_data  <= {1'b0, rx_shift};
            ev_parity  <= rx_pc[PC_PARITY_BIT] && rx_par_err;
            ev_framing <= !rxd_in;
            ev_overrun <= !rx_wr_if.ready;
            rx_par_err <= 1'b0;
            rx_state   <= RX_IDLE;
          end
      endcase
    end
  end

  // RX output stage keeps the user-side port registered
  assign rx_rd_if.ready = !rx_valid_out || rx_ready_in;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rx_valid_out <= 1'b0;
      rx_data_out  <= '0;
    end
    else if (rx_rd_if.ready)
    begin
      rx_valid_out <= rx_rd_if.valid;
      rx_data_out  <= rx_rd_if.data;
    end
  end

  // Sticky error causes: an event in the clearing cycle wins over the clear
  logic [2:0]       err_flags;
  wire  [2:0]       err_events = {ev_overrun, ev_framing, ev_parity};
  wire  [2:0]       next_err   = (err_flags & ~int_clear_in[INT_OVERRUN:INT_PARITY]) | err_events;
  wire  [INT_W-1:0] next_int_status = {tx_empty_out && tx_state == TX_IDLE,
                                       rx_valid_out, next_err};

  // Status and interrupt line
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      err_flags      <= '0;
      int_status_out <= '0;
      irq_out        <= 1'b0;
      tx_idle_out    <= 1'b1;
      rx_idle_out    <= 1'b1;
    end
    else
    begin
      err_flags      <= next_err;
      int_status_out <= next_int_status;
      irq_out        <= |(next_int_status & int_enable_in);
      tx_idle_out    <= (tx_state == TX_IDLE);
      rx_idle_out    <= (rx_state == RX_IDLE);
    end
  end
endmodule : async_serial_controller

/* rtl/bit_rate_gen.sv */
// Sample-rate generator: a down counter reloaded from the divisor.
// Assumes the divisor is stable or changes only between characters.
`timescale 1ns/1ns
module bit_rate_gen
  import serial_ctrl_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] divisor_in,
  input  wire logic         reload_in,
  output logic      [W-1:0] count_out,
  output logic              tick_out
);
  // One tick every divisor + 1 clocks
  assign tick_out = (count_out == '0);

  // Reload at zero or when software writes the counter
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      count_out <= '0;
    else if (reload_in || tick_out)
      count_out <= divisor_in;
    else
      count_out <= count_out - W'(1);
  end
endmodule : bit_rate_gen

/* rtl/serial_ctrl_pkg.sv */
// Constants, state types and shared helpers for the async serial controller.
// Assumes one system clock at CLK_HZ.
package serial_ctrl_pkg;

  // Clock and reset bit rate
  localparam int             CLK_HZ             = 100_000_000;
  localparam int             RESET_BAUD_HZ      = 115_200;
  localparam int             SAMPLE_BASE        = 16;
  localparam int             DIV_W              = 16;
  localparam int             SF_W               = 4;
  localparam int             SAMP_W             = 5;
  localparam int             BITN_W             = 4;
  localparam logic [SF_W-1:0] RESET_SAMPLE_FIELD = 4'hf;
  localparam int             RESET_SAMPLES      = SAMPLE_BASE + int'(RESET_SAMPLE_FIELD);
  // Divisor giving the default rate: 28 x 31 = 868 clocks per bit at 100 MHz
  localparam logic [DIV_W-1:0] RESET_DIVISOR =
    DIV_W'(CLK_HZ / (RESET_BAUD_HZ * RESET_SAMPLES) - 1);

  // Character and FIFO layout
  localparam int             CHAR_W        = 10;
  localparam int             FIFO_DEPTH    = 32;
  localparam int             EXT_FLAG_BIT  = 9;
  localparam int             NINTH_BIT     = 8;
  localparam logic [CHAR_W-1:0] BREAK_CHAR = 10'h200;
  localparam logic [CHAR_W-1:0] IDLE_CHAR  = 10'h3ff;
  localparam logic [BITN_W-1:0] BITS_8     = 4'h8;
  localparam logic [BITN_W-1:0] BITS_9     = 4'h9;
  localparam logic [BITN_W-1:0] EXT_BITS   = 4'hb;

  // Parity control field encodings
  localparam logic [1:0]     PC_ONE_STOP   = 2'h0;
  localparam logic [1:0]     PC_TWO_STOP   = 2'h1;
  localparam logic [1:0]     PC_EVEN       = 2'h2;
  localparam logic [1:0]     PC_ODD        = 2'h3;
  localparam int             PC_PARITY_BIT = 1;
  localparam int             PC_ODD_BIT    = 0;

  // Interrupt cause positions
  localparam int             INT_W        = 5;
  localparam int             INT_PARITY   = 0;
  localparam int             INT_FRAMING  = 1;
  localparam int             INT_OVERRUN  = 2;
  localparam int             INT_RX_READY = 3;
  localparam int             INT_TX_EMPTY = 4;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_EXT} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_HALF, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

  // Samples in one bit: 16 + field, LSB flipped on alternate bits when enabled
  function automatic logic [SAMP_W-1:0] bit_samples(input logic [SF_W-1:0] field,
                                                    input logic            alt,
                                                    input logic            flip);
    bit_samples = (SAMP_W'(SAMPLE_BASE) + SAMP_W'(field)) ^ SAMP_W'(alt & flip);
  endfunction : bit_samples

  // Parity bit for the data bits; odd selects odd parity
  function automatic logic parity_of(input logic [NINTH_BIT:0] data,
                                     input logic               odd);
    parity_of = (^data) ^ odd;
  endfunction : parity_of

endpackage : serial_ctrl_pkg

/* rtl/serial_fifo.sv */
// Synchronous FIFO with registered full, empty and half-full flags.
// Assumes DEPTH is a power of two so the pointers wrap naturally.
`timescale 1ns/1ns
module serial_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 32
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  stream_if.snk     wr,
  stream_if.src     rd,
  output logic      full_out,
  output logic      half_out,
  output logic      empty_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  wire           push = wr.valid & ~full_out;
  wire           pop  = rd.ready & ~empty_out;

  // Flags are registered so ready and valid never ripple through logic
  assign wr.ready   = ~full_out;
  assign rd.valid   = ~empty_out;
  assign rd.data    = mem[rptr];
  assign next_count = count + CW'(push) - CW'(pop);

  // Storage has no reset; only pointers and flags need a defined value
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wptr] <= wr.data;
  end

  // Pointers, level and flags
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      wptr      <= '0;
      rptr      <= '0;
      count     <= '0;
      full_out  <= 1'b0;
      half_out  <= 1'b0;
      empty_out <= 1'b1;
    end
    else
    begin
      wptr      <= wptr + AW'(push);
      rptr      <= rptr + AW'(pop);
      count     <= next_count;
      full_out  <= (next_count == CW'(DEPTH));
      half_out  <= (next_count >= CW'(DEPTH / 2));
      empty_out <= (next_count == '0);
    end
  end
endmodule : serial_fifo

/* rtl/stream_if.sv */
// Valid/ready word carrier between the controller and its FIFOs.
// Assumes both ends share one clock; a word moves when valid and ready are high.
`timescale 1ns/1ns
interface stream_if #(parameter int W = 10);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : stream_if
